// ===== verilog/iolfc_pkg.sv
// shared constants of the I/O line filter and change-interrupt block
package iolfc_pkg;
  localparam int          LINES      = 32;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          WARM_W     = 4;
  // register byte offsets
  localparam logic [7:0]  OFF_OWN_SET  = 8'h00;
  localparam logic [7:0]  OFF_OWN_CLR  = 8'h04;
  localparam logic [7:0]  OFF_OWN_STS  = 8'h08;
  localparam logic [7:0]  OFF_FLT_ON   = 8'h10;
  localparam logic [7:0]  OFF_FLT_OFF  = 8'h14;
  localparam logic [7:0]  OFF_FLT_STS  = 8'h18;
  localparam logic [7:0]  OFF_OUT_LVL  = 8'h1C;
  localparam logic [7:0]  OFF_GATE_SET = 8'h20;
  localparam logic [7:0]  OFF_GATE_CLR = 8'h24;
  localparam logic [7:0]  OFF_GATE_STS = 8'h28;
  localparam logic [7:0]  OFF_PIN_LVL  = 8'h30;
  localparam logic [7:0]  OFF_IRQ_ON   = 8'h40;
  localparam logic [7:0]  OFF_IRQ_OFF  = 8'h44;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h48;
  localparam logic [7:0]  OFF_IRQ_STS  = 8'h4C;
  // reset values
  localparam logic [31:0] RST_OWNER  = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ZERO   = 32'h00000000;
endpackage : iolfc_pkg

// ===== verilog/iolfc_line_if.sv
// per-line levels passed between the register side and the line filters
`timescale 1ns/1ps
interface iolfc_line_if;
  import iolfc_pkg::*;
  logic [LINES-1:0] filt_en;
  logic [LINES-1:0] raw;
  logic [LINES-1:0] level;
  logic [LINES-1:0] change;
  modport regs (output filt_en, input raw, input level, input change);
  modport filt (input filt_en, output raw, output level, output change);
endinterface : iolfc_line_if

// ===== verilog/iolfc_filter.sv
// pin synchronisers, glitch filters and change detection for all lines
`timescale 1ns/1ps
module iolfc_filter
  import iolfc_pkg::*;
(
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  // pins
  input  wire logic [LINES-1:0] pin_i,
  // line levels
  iolfc_line_if.filt            ln
);
  typedef struct packed {
    logic [LINES-1:0]  p1;
    logic [LINES-1:0]  p2;
    logic [LINES-1:0]  pprev;
    logic [LINES-1:0]  nr;
    logic [LINES-1:0]  filt;
    logic [LINES-1:0]  sel;
    logic [LINES-1:0]  change;
    logic [WARM_W-1:0] warm;
  } iolfc_flt_t;

  iolfc_flt_t       s;
  iolfc_flt_t       next_s;
  logic [LINES-1:0] n1;
  logic [LINES-1:0] n2;
  logic [LINES-1:0] agree;
  logic [LINES-1:0] hold;

  // falling-edge chain gives the half-period samples the filter needs
  always_ff @(negedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      n1 <= '0;
      n2 <= '0;
    end else begin
      n1 <= pin_i;
      n2 <= n1;
    end
  end

  // samples in time order: pprev, nr (half later), p2 (half later)
  always_comb begin
    next_s       = s;
    next_s.p1    = pin_i;
    next_s.p2    = s.p1;
    next_s.pprev = s.p2;
    next_s.nr    = n2;
    agree        = ~(s.p2 ^ s.nr);
    hold         = (s.p2 ^ s.nr) & (s.nr ^ s.pprev);
    // two adjacent half-period samples must agree to move the output
    next_s.filt  = (agree & s.p2) | (~agree & ~hold & s.nr) |
                   (hold & s.filt);
    next_s.sel   = (ln.filt_en & next_s.filt) |
                   (~ln.filt_en & s.p2);
    next_s.warm  = {s.warm[WARM_W-2:0], 1'b1};
    // either edge counts; masked until the pipeline holds real samples
    next_s.change = (next_s.sel ^ s.sel) &
                    {LINES{s.warm[WARM_W-1]}};
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // peripherals see the synchronised pin, never the filtered one
  assign ln.raw    = s.p2;
  assign ln.level  = s.sel;
  assign ln.change = s.change;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  glitch_hold_a: assert property (
    ##1 (((s.filt ^ $past(s.filt)) & $past(hold)) == '0))
    else $error("filter moved on a lone half-period sample");
  pass_level_a: assert property (
    ##1 (((s.filt ^ $past(s.p2)) & $past(agree)) == '0))
    else $error("filter missed two agreeing samples");
  change_edge_a: assert property (
    s.warm[WARM_W-1] |-> (s.change == (s.sel ^ $past(s.sel))))
    else $error("change flag does not match a level edge");
  periph_raw_a: assert property (
    ##3 (ln.raw == $past(pin_i, 2)))
    else $error("peripheral input is not the plain pin");
endmodule : iolfc_filter

// ===== verilog/iolfc_top.sv
// APB register file and pin ownership for 32 I/O lines
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module iolfc_top
  import iolfc_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // pins and peripherals
  input  wire logic [LINES-1:0]  pin_i,
  output logic      [LINES-1:0]  pin_owner_o,
  output logic      [LINES-1:0]  out_level_o,
  output logic      [LINES-1:0]  periph_in_o,
  // interrupt toward the system interrupt controller
  output logic                   irq_o
);
  typedef struct packed {
    logic [LINES-1:0]  owner;
    logic [LINES-1:0]  filt;
    logic [LINES-1:0]  gate;
    logic [LINES-1:0]  odsr;
    logic [LINES-1:0]  mask;
    logic [LINES-1:0]  isr;
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              err;
    logic              irq;
  } iolfc_regs_t;

  iolfc_regs_t      s;
  iolfc_regs_t      next_s;
  logic             acc;
  logic             wr;
  logic             rd;
  logic             hit;
  logic [DATA_W-1:0] rmux;
  logic             own_wr;
  logic             isr_rd;

  iolfc_line_if ln ();

  // filtering and change detection run on the pin, not on the owner
  iolfc_filter u_filter (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (pin_i),
    .ln     (ln.filt)
  );

  function automatic logic is_off(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        off);
    is_off = (a == off);
  endfunction : is_off

  // read value and decode of one address
  always_comb begin
    hit  = 1'b1;
    rmux = '0;
    unique case (paddr_i)
      OFF_OWN_STS:  rmux = s.owner;
      OFF_FLT_STS:  rmux = s.filt;
      OFF_OUT_LVL:  rmux = s.odsr;
      OFF_GATE_STS: rmux = s.gate;
      OFF_PIN_LVL:  rmux = ln.level;
      OFF_IRQ_MASK: rmux = s.mask;
      OFF_IRQ_STS:  rmux = s.isr;
      OFF_OWN_SET, OFF_OWN_CLR, OFF_FLT_ON, OFF_FLT_OFF,
      OFF_GATE_SET, OFF_GATE_CLR, OFF_IRQ_ON, OFF_IRQ_OFF: rmux = '0;
      default:      hit  = 1'b0;
    endcase
  end

  always_comb begin
    next_s = s;
    acc    = psel_i & penable_i;
    // effects only at the edge where pready is seen high
    wr     = acc & s.ready & pwrite_i;
    rd     = acc & s.ready & ~pwrite_i;
    // one wait state keeps every bus output on a flip-flop
    next_s.ready = acc & ~s.ready;
    if (acc && !s.ready) begin
      next_s.rdata = pwrite_i ? '0 : rmux;
      next_s.err   = ~hit;
    end else begin
      // answer stands in the ready cycle only, zero elsewhere
      next_s.rdata = '0;
      next_s.err   = 1'b0;
    end
    if (wr) begin
      if (is_off(paddr_i, OFF_OWN_SET))
        next_s.owner = s.owner | pwdata_i;
      if (is_off(paddr_i, OFF_OWN_CLR))
        next_s.owner = s.owner & ~pwdata_i;
      if (is_off(paddr_i, OFF_FLT_ON))
        next_s.filt = s.filt | pwdata_i;
      if (is_off(paddr_i, OFF_FLT_OFF))
        next_s.filt = s.filt & ~pwdata_i;
      if (is_off(paddr_i, OFF_GATE_SET))
        next_s.gate = s.gate | pwdata_i;
      if (is_off(paddr_i, OFF_GATE_CLR))
        next_s.gate = s.gate & ~pwdata_i;
      if (is_off(paddr_i, OFF_OUT_LVL))
        next_s.odsr = (s.odsr & ~s.gate) | (pwdata_i & s.gate);
      if (is_off(paddr_i, OFF_IRQ_ON))
        next_s.mask = s.mask | pwdata_i;
      if (is_off(paddr_i, OFF_IRQ_OFF))
        next_s.mask = s.mask & ~pwdata_i;
    end
    // clear only what the read returned, so a late change survives
    if (rd && is_off(paddr_i, OFF_IRQ_STS))
      next_s.isr = s.isr & ~s.rdata;
    next_s.isr = next_s.isr | ln.change;
    next_s.irq = |(next_s.isr & next_s.mask);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s       <= '0;
      s.owner <= RST_OWNER;
    end else begin
      s <= next_s;
    end
  end

  assign ln.filt_en  = s.filt;
  assign prdata_o    = s.rdata;
  assign pready_o    = s.ready;
  assign pslverr_o   = s.err;
  assign pin_owner_o = s.owner;
  assign out_level_o = s.odsr;
  assign periph_in_o = ln.raw;
  assign irq_o       = s.irq;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence wr_done(logic [7:0] off);
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == off;
  endsequence
  sequence rd_done(logic [7:0] off);
    psel_i && penable_i && pready_o && !pwrite_i && paddr_i == off;
  endsequence

  filt_on_a: assert property (
    wr_done(OFF_FLT_ON) |=> ((s.filt & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("filter-on did not set status bits");
  filt_off_a: assert property (
    wr_done(OFF_FLT_OFF) |=> ((s.filt & $past(pwdata_i)) == '0))
    else $error("filter-off did not clear status bits");
  mask_cmd_a: assert property (
    wr_done(OFF_IRQ_OFF) |=> ((s.mask & $past(pwdata_i)) == '0))
    else $error("irq-off did not clear mask bits");
  owner_set_a: assert property (
    wr_done(OFF_OWN_SET) |=>
      (pin_owner_o == ($past(pin_owner_o) | $past(pwdata_i))))
    else $error("owner-set result wrong");
  owner_clr_a: assert property (
    wr_done(OFF_OWN_CLR) |=>
      (pin_owner_o == ($past(pin_owner_o) & ~$past(pwdata_i))))
    else $error("owner-clear result wrong");
  gate_out_a: assert property (
    wr_done(OFF_OUT_LVL) |=>
      (((out_level_o ^ $past(out_level_o)) & ~$past(s.gate)) == '0))
    else $error("output level changed on a blocked line");
  isr_set_a: assert property (
    ##1 ((s.isr & $past(ln.change)) == $past(ln.change)))
    else $error("change did not set status");
  isr_clear_a: assert property (
    rd_done(OFF_IRQ_STS) |=>
      ((s.isr & $past(prdata_o) & ~$past(ln.change)) == '0))
    else $error("status read did not clear returned bits");
  irq_or_a: assert property (
    ##1 (irq_o == |(s.isr & s.mask)))
    else $error("interrupt not the OR of masked status");
  bus_wait_a: assert property (
    (psel_i && penable_i && !pready_o) |=> pready_o)
    else $error("slave did not answer after one wait state");

  // command helpers for the keep-checks below
  assign own_wr = wr & (is_off(paddr_i, OFF_OWN_SET) |
                        is_off(paddr_i, OFF_OWN_CLR));
  assign isr_rd = rd & is_off(paddr_i, OFF_IRQ_STS);

  sequence setup_phase;
    psel_i && !penable_i;
  endsequence
  sequence wait_phase;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence masked_change;
    ((ln.change & s.mask) != '0) && !wr;
  endsequence

  // bus handshake
  bus_order_a: assert property (
    setup_phase ##1 wait_phase |=> pready_o)
    else $error("access phase did not end after one wait state");
  ready_pulse_a: assert property (
    pready_o |=> !pready_o)
    else $error("ready stood for more than one cycle");
  ready_idle_a: assert property (
    !psel_i |=> !pready_o)
    else $error("ready raised without a selected transfer");
  err_ready_a: assert property (
    pslverr_o |-> pready_o)
    else $error("error flag outside the ready cycle");
  rdata_idle_a: assert property (
    !pready_o |-> (prdata_o == '0))
    else $error("read data not zero outside the ready cycle");
  wr_rdata_a: assert property (
    (psel_i && penable_i && pwrite_i && pready_o) |->
      (prdata_o == '0))
    else $error("write returned nonzero read data");
  unmapped_wr_a: assert property (
    (wr && !hit) |=>
      ($stable(pin_owner_o) && $stable(out_level_o) &&
       $stable(s.filt) && $stable(s.gate) && $stable(s.mask)))
    else $error("unmapped write changed a register");

  // command registers: ones act, zeros leave the bit alone
  filt_keep_a: assert property (
    wr_done(OFF_FLT_ON) |=>
      ((s.filt & ~$past(pwdata_i)) == ($past(s.filt) & ~$past(pwdata_i))))
    else $error("filter-on changed a line written with zero");
  filt_off_keep_a: assert property (
    wr_done(OFF_FLT_OFF) |=>
      ((s.filt | $past(pwdata_i)) == ($past(s.filt) | $past(pwdata_i))))
    else $error("filter-off changed a line written with zero");
  mask_on_a: assert property (
    wr_done(OFF_IRQ_ON) |=>
      ((s.mask & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("irq-on did not set mask bits");
  mask_keep_a: assert property (
    wr_done(OFF_IRQ_ON) |=>
      ((s.mask & ~$past(pwdata_i)) == ($past(s.mask) & ~$past(pwdata_i))))
    else $error("irq-on changed a line written with zero");
  mask_off_keep_a: assert property (
    wr_done(OFF_IRQ_OFF) |=>
      ((s.mask | $past(pwdata_i)) == ($past(s.mask) | $past(pwdata_i))))
    else $error("irq-off changed a line written with zero");
  gate_set_a: assert property (
    wr_done(OFF_GATE_SET) |=>
      ((s.gate & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("gate-set did not open the written lines");
  gate_keep_a: assert property (
    wr_done(OFF_GATE_SET) |=>
      ((s.gate & ~$past(pwdata_i)) == ($past(s.gate) & ~$past(pwdata_i))))
    else $error("gate-set changed a line written with zero");
  gate_clr_a: assert property (
    wr_done(OFF_GATE_CLR) |=>
      ((s.gate & $past(pwdata_i)) == '0))
    else $error("gate-clear did not close the written lines");
  gate_clr_keep_a: assert property (
    wr_done(OFF_GATE_CLR) |=>
      ((s.gate | $past(pwdata_i)) == ($past(s.gate) | $past(pwdata_i))))
    else $error("gate-clear changed a line written with zero");
  gate_pass_a: assert property (
    wr_done(OFF_OUT_LVL) |=>
      (((out_level_o ^ $past(pwdata_i)) & $past(s.gate)) == '0))
    else $error("output level not written on an open line");
  owner_keep_a: assert property (
    !own_wr |=> $stable(pin_owner_o))
    else $error("owner changed without an owner command");

  // status and interrupt
  isr_hold_a: assert property (
    !isr_rd |=> ((~s.isr & $past(s.isr)) == '0))
    else $error("status bit fell without a status read");
  isr_read_a: assert property (
    rd_done(OFF_IRQ_STS) |-> (prdata_o == $past(s.isr)))
    else $error("status read did not return pending bits");
  level_read_a: assert property (
    rd_done(OFF_PIN_LVL) |-> (prdata_o == $past(ln.level)))
    else $error("pin level read does not match the line level");
  irq_follow_a: assert property (
    masked_change |=> irq_o)
    else $error("masked change did not raise the interrupt");
  irq_quiet_a: assert property (
    (s.mask == '0) |-> !irq_o)
    else $error("interrupt raised with every line masked");
endmodule : iolfc_top

// ===== verification/iolfc_pin_model.sv
// behavioural model of the pins outside the controller
`timescale 1ns/1ps
module iolfc_pin_model
  import iolfc_pkg::*;
(
  // pin levels toward the controller
  output logic [LINES-1:0] pin_o
);
  initial pin_o = 32'h00000000;
  // lasting flip, launched on a clock edge like any other input
  task automatic toggle(input logic [LINES-1:0] m);
    pin_o <= pin_o ^ m;
  endtask : toggle
  // short excursion off the edges, width in ns, to probe the filters
  task automatic pulse(input logic [LINES-1:0] m, input realtime w);
    pin_o = pin_o ^ m;
    #(w);
    pin_o = pin_o ^ m;
  endtask : pulse
endmodule : iolfc_pin_model

// ===== verification/iolfc_tb.sv
// self-checking bench of the I/O line filter and change-interrupt block
`timescale 1ns/1ps
module iolfc_tb
  import iolfc_pkg::*;
;
  logic              mclk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              psel_i = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = 8'h00;
  logic [DATA_W-1:0] pwdata_i = 32'h00000000;
  logic [DATA_W-1:0] prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic [LINES-1:0]  pin_i;
  logic [LINES-1:0]  pin_owner_o;
  logic [LINES-1:0]  out_level_o;
  logic [LINES-1:0]  periph_in_o;
  logic              irq_o;
  logic [32:0]       notes[$];
  logic [32:0]       e;
  logic [31:0]       own, ol, gate, mask, t, r, flt;
  int                seed = 56;
  int                mismatches = 0;
  int                num_checks = 0;

  iolfc_top i_iolfc_top (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_i,
    .pin_owner_o, .out_level_o, .periph_in_o, .irq_o);
  iolfc_pin_model i_pins (.pin_o(pin_i));

  always #2 mclk_i = ~mclk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // setup then access; psel stays up so a following call runs back to back
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] x);
    notes.push_back(x);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, {1'b0, RST_ZERO});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, RST_ZERO, {1'b0, x});
  endtask : rd

  task automatic idle();
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : idle

  // read data and error flag are judged only at the completing edge
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1) begin
      e = (notes.size() > 0) ? notes.pop_front() : 33'h1FFFFFFFF;
      chk(prdata_o, e[31:0]);
      chk({31'h0, pslverr_o}, {31'h0, e[32]});
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    rd(OFF_OWN_STS, RST_OWNER);
    rd(OFF_FLT_STS, RST_ZERO);
    rd(OFF_GATE_STS, RST_ZERO);
    rd(OFF_OWN_SET, RST_ZERO);
    xfer(1'b0, 8'h2C, RST_ZERO, {1'b1, RST_ZERO});
    xfer(1'b1, 8'hFC, 32'hFFFFFFFF, {1'b1, RST_ZERO});
    r = $random(seed);
    wr(OFF_OWN_CLR, r);
    own = RST_OWNER & ~r;
    rd(OFF_OWN_STS, own);
    r = $random(seed);
    wr(OFF_OWN_SET, r);
    own = own | r;
    rd(OFF_OWN_STS, own);
    gate = $random(seed);
    wr(OFF_GATE_SET, gate);
    r = $random(seed);
    wr(OFF_OUT_LVL, r);
    ol = r & gate;
    rd(OFF_OUT_LVL, ol);
    r = $random(seed);
    wr(OFF_GATE_CLR, r);
    gate = gate & ~r;
    rd(OFF_GATE_STS, gate);
    r = $random(seed);
    wr(OFF_OUT_LVL, r);
    ol = (ol & ~gate) | (r & gate);
    rd(OFF_OUT_LVL, ol);
    wr(OFF_FLT_ON, 32'h0000FFFF);
    wr(OFF_FLT_OFF, 32'h000000F0);
    flt = 32'h0000FF0F;
    rd(OFF_FLT_STS, flt);
    mask = $random(seed) | 32'h00000010;
    wr(OFF_IRQ_ON, mask);
    wr(OFF_IRQ_OFF, 32'h0000000F);
    mask = mask & ~32'h0000000F;
    rd(OFF_IRQ_MASK, mask);
    rd(OFF_IRQ_STS, RST_ZERO);
    idle();
    chk(pin_owner_o, own);
    chk(out_level_o, ol);
    // same lines flipped twice: rising then falling edges
    t = $random(seed);
    for (int k = 0; k < 2; k++) begin
      i_pins.toggle(t);
      repeat (12) @(posedge mclk_i);
      chk({31'h0, irq_o}, {31'h0, |(t & mask)});
      chk(periph_in_o, pin_i);
      rd(OFF_PIN_LVL, pin_i);
      rd(OFF_IRQ_STS, t);
      rd(OFF_IRQ_STS, RST_ZERO);
      idle();
      chk({31'h0, irq_o}, 32'h00000000);
    end
    // half-period glitch across a falling edge must vanish
    #0.5;
    i_pins.pulse(flt, 2.0);
    repeat (12) @(posedge mclk_i);
    rd(OFF_IRQ_STS, RST_ZERO);
    idle();
    // one full period must get through on every line
    #0.5;
    i_pins.pulse(32'hFFFFFFFF, 4.0);
    repeat (12) @(posedge mclk_i);
    rd(OFF_IRQ_STS, 32'hFFFFFFFF);
    idle();
    wrap_up();
  end
endmodule : iolfc_tb
